// ==== verilog/wcache_map.svh ====
// Constants of the disk write cache controller
`ifndef WCACHE_MAP_SVH
`define WCACHE_MAP_SVH
`define OP_WRITE_SECTORS 8'h30
`define OP_WRITE_MULTIPLE 8'hc5
`define OP_WRITE_DMA 8'hca
`define OP_SET_FEATURES 8'hef
`define FEAT_WC_ENABLE 8'h02
`define FEAT_WC_DISABLE 8'h82
`define WC_RESET_ENABLE 1'b1
`define RETRY_LIMIT 8
`endif

// ==== verilog/wcache_pkg.sv ====
// Types of the disk write cache controller
package wcache_pkg;
	typedef enum logic [1:0] {H_IDLE, H_XFER, H_DRAIN} host_state_e;
	typedef enum logic [1:0] {M_IDLE, M_LOAD, M_RUN, M_REASSIGN} med_state_e;
endpackage

// ==== verilog/wcache_extent_mem.sv ====
// Small memory holding pending write extents
`timescale 1ns/100ps
module wcache_extent_mem #(
	parameter int WIDTH = 37,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic sys_clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Write port
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge sys_clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule

// ==== verilog/disk_write_cache_control.sv ====
// Write-back cache controller between ATA command side and medium
`timescale 1ns/100ps
`include "wcache_map.svh"
module disk_write_cache_control import wcache_pkg::*; #(
	parameter int LBA_W = 28,
	parameter int CNT_W = 8,
	parameter int DEPTH = 8,
	parameter int RETRIES = `RETRY_LIMIT
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_opcode,
	input wire logic [7:0] cmd_feature,
	input wire logic [LBA_W-1:0] cmd_lba,
	input wire logic [CNT_W-1:0] cmd_count,
	output logic xfer_go,
	input wire logic host_xfer_done,
	output logic cmd_pass,
	output logic irq_done,
	output logic irq_abort,
	output logic stat_ok,
	output logic stat_err,
	output logic cache_en,
	input wire logic hard_reset_req,
	input wire logic soft_reset_req,
	output logic hard_go,
	output logic soft_go,
	output logic med_start,
	output logic [LBA_W-1:0] med_lba,
	output logic [CNT_W-1:0] med_count,
	output logic med_seek,
	input wire logic med_done,
	input wire logic med_fail,
	output logic reassign_req,
	input wire logic reassign_ok,
	input wire logic reassign_fail,
	output logic pending
);
	localparam int AW = $clog2(DEPTH);
	localparam int EW = LBA_W + CNT_W + 1;

	// ************************************
	// Decoding and bookkeeping
	// ************************************
	function automatic logic is_write(input logic [7:0] op);
		return op == `OP_WRITE_SECTORS || op == `OP_WRITE_MULTIPLE ||
			op == `OP_WRITE_DMA;
	endfunction

	host_state_e h_state;
	med_state_e m_state;
	logic [AW-1:0] head, tail;
	logic [AW:0] qcnt;
	logic [LBA_W-1:0] next_lba;
	logic err_pending, through, drain_feat, feat_val;
	logic hard_hold, soft_hold;
	logic [EW-1:0] rd_entry;
	logic [7:0] tries;
	logic accept, push, pop, flush, seq_in, drain_end, write_cmd;

	// Checks sample on the system clock and rest during reset
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	assign pending = qcnt != '0 || m_state != M_IDLE;
	assign cmd_ready = h_state == H_IDLE && qcnt != (AW+1)'(DEPTH) &&
		m_state != M_REASSIGN && !hard_hold && !soft_hold;
	assign accept = cmd_valid && cmd_ready;
	assign write_cmd = is_write(cmd_opcode);
	// A write is queued even with an error stored; it is reported after
	assign push = accept && write_cmd;
	// Sequential only while the previous write is still queued or on the medium
	assign seq_in = cmd_lba == next_lba && pending;
	assign pop = m_state == M_IDLE && qcnt != '0;
	assign flush = m_state == M_REASSIGN && reassign_fail;
	assign drain_end = h_state == H_DRAIN && !pending;

	// Extent storage
	wcache_extent_mem #(.WIDTH(EW), .DEPTH(DEPTH), .AW(AW)) u_mem (
		.sys_clk(sys_clk),
		.wr_en(push),
		.wr_addr(tail),
		.wr_data({seq_in, cmd_lba, cmd_count}),
		.rd_addr(head),
		.rd_data(rd_entry)
	);

	// Queue pointers; a failed recovery drops all remaining data
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			head <= '0;
			tail <= '0;
			qcnt <= '0;
		end else if (flush) begin
			head <= '0;
			tail <= '0;
			qcnt <= '0;
		end else begin
			if (push) begin
				tail <= AW'(tail + 1'b1);
			end
			if (pop) begin
				head <= AW'(head + 1'b1);
			end
			qcnt <= (AW+1)'(qcnt + push - pop);
		end
	end

	// Address following the last accepted write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			next_lba <= '0;
		end else if (push) begin
			next_lba <= LBA_W'(cmd_lba + cmd_count);
		end
	end

	// ************************************
	// Host command side
	// ************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			h_state <= H_IDLE;
			through <= 1'b0;
			drain_feat <= 1'b0;
			feat_val <= 1'b0;
			xfer_go <= 1'b0;
			cmd_pass <= 1'b0;
		end else begin
			xfer_go <= 1'b0;
			cmd_pass <= 1'b0;
			unique case (h_state)
				H_IDLE: begin
					if (accept && write_cmd) begin
						xfer_go <= 1'b1;
						// Error or disabled cache: complete after medium
						through <= !cache_en || err_pending;
						h_state <= H_XFER;
					end else if (accept && err_pending) begin
						h_state <= H_IDLE;
					end else if (accept && cmd_opcode == `OP_SET_FEATURES &&
						(cmd_feature == `FEAT_WC_ENABLE ||
						cmd_feature == `FEAT_WC_DISABLE)) begin
						drain_feat <= 1'b1;
						feat_val <= cmd_feature == `FEAT_WC_ENABLE;
						h_state <= H_DRAIN;
					end else if (accept) begin
						cmd_pass <= 1'b1;
					end
				end
				H_XFER: begin
					if (host_xfer_done) begin
						h_state <= through ? H_DRAIN : H_IDLE;
					end
				end
				H_DRAIN: begin
					if (drain_end) begin
						drain_feat <= 1'b0;
						through <= 1'b0;
						h_state <= H_IDLE;
					end
				end
				default: h_state <= H_IDLE;
			endcase
		end
	end

	// Completion interrupts and ATA status
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_done <= 1'b0;
			irq_abort <= 1'b0;
			stat_ok <= 1'b0;
			stat_err <= 1'b0;
		end else begin
			irq_done <= 1'b0;
			irq_abort <= 1'b0;
			if ((h_state == H_IDLE && accept && !write_cmd && err_pending) ||
				(drain_end && err_pending)) begin
				irq_abort <= 1'b1;
				stat_ok <= 1'b0;
				stat_err <= 1'b1;
			end else if ((h_state == H_XFER && host_xfer_done && !through) ||
				drain_end) begin
				irq_done <= 1'b1;
				stat_ok <= 1'b1;
				stat_err <= 1'b0;
			end
		end
	end

	// Completion, status and refusal checks
	property p_early_done;
		h_state == H_XFER && host_xfer_done && !through |=> irq_done;
	endproperty
	a_early_done: assert property (p_early_done)
		else $error("early completion missing");
	property p_ok_status;
		irq_done |-> stat_ok && !stat_err;
	endproperty
	a_ok_status: assert property (p_ok_status)
		else $error("normal end without ok status");
	property p_refuse;
		accept && !write_cmd && err_pending |=>
			irq_abort && stat_err && !cmd_pass ##1 !err_pending;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("command not refused after error");
	property p_write_then_err;
		drain_end && err_pending |=> irq_abort && !irq_done;
	endproperty
	a_write_then_err: assert property (p_write_then_err)
		else $error("error not reported after write");

	// Stored error, cleared when it is reported
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			err_pending <= 1'b0;
		end else if (flush) begin
			err_pending <= 1'b1;
		end else if ((h_state == H_IDLE && accept && !write_cmd) ||
			drain_end) begin
			err_pending <= 1'b0;
		end
	end

	// Cache enable: power-up default, features, auto-disable on failure
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cache_en <= `WC_RESET_ENABLE;
		end else if (flush) begin
			cache_en <= 1'b0;
		end else if (drain_end && drain_feat && !err_pending) begin
			cache_en <= feat_val;
		end
	end

	// Failed recovery empties the queue and turns caching off
	property p_fail_flush;
		m_state == M_REASSIGN && reassign_fail |=>
			qcnt == '0 && !cache_en && err_pending;
	endproperty
	a_fail_flush: assert property (p_fail_flush)
		else $error("failure did not flush and disable");

	// Resets held until all buffered data is on the medium
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hard_hold <= 1'b0;
			soft_hold <= 1'b0;
			hard_go <= 1'b0;
			soft_go <= 1'b0;
		end else begin
			hard_go <= hard_hold && !pending;
			soft_go <= soft_hold && !hard_hold && !pending;
			hard_hold <= hard_reset_req || (hard_hold && pending);
			soft_hold <= soft_reset_req || (soft_hold && pending);
		end
	end

	// A reset is let go only after the medium has gone quiet
	property p_reset_held;
		(hard_go || soft_go) |-> $past(!pending);
	endproperty
	a_reset_held: assert property (p_reset_held)
		else $error("reset ran with data pending");

	// ************************************
	// Medium side
	// ************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			m_state <= M_IDLE;
			tries <= '0;
			med_start <= 1'b0;
			med_lba <= '0;
			med_count <= '0;
			med_seek <= 1'b0;
			reassign_req <= 1'b0;
		end else begin
			med_start <= 1'b0;
			reassign_req <= 1'b0;
			unique case (m_state)
				M_IDLE: begin
					if (pop) begin
						m_state <= M_LOAD;
					end
				end
				M_LOAD: begin
					med_start <= 1'b1;
					med_lba <= rd_entry[CNT_W +: LBA_W];
					med_count <= rd_entry[CNT_W-1:0];
					med_seek <= !rd_entry[EW-1];
					tries <= '0;
					m_state <= M_RUN;
				end
				M_RUN: begin
					if (med_done) begin
						m_state <= M_IDLE;
					end else if (med_fail && tries < 8'(RETRIES)) begin
						tries <= 8'(tries + 1'b1);
						med_start <= 1'b1;
						med_seek <= 1'b1;
					end else if (med_fail) begin
						reassign_req <= 1'b1;
						m_state <= M_REASSIGN;
					end
				end
				M_REASSIGN: begin
					if (reassign_ok || reassign_fail) begin
						m_state <= M_IDLE;
					end
				end
			endcase
		end
	end

	// Chained writes skip the search, good spares stay quiet
	property p_seq_noseek;
		m_state == M_LOAD && rd_entry[EW-1] |=> med_start && !med_seek;
	endproperty
	a_seq_noseek: assert property (p_seq_noseek)
		else $error("sequential write searched");
	property p_reassign_quiet;
		m_state == M_REASSIGN && reassign_ok && !err_pending |=>
			!err_pending ##1 !irq_abort;
	endproperty
	a_reassign_quiet: assert property (p_reassign_quiet)
		else $error("abort after good reassignment");
endmodule

// ==== dv/wcache_medium_model.sv ====
// Behavioural disk channel answering medium writes and reassignments
`timescale 1ns/100ps
module wcache_medium_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic med_start,
	input wire logic reassign_req,
	input wire logic slow,
	input wire logic fail_all,
	input wire logic spare_ok,
	output logic med_done,
	output logic med_fail,
	output logic reassign_ok,
	output logic reassign_fail
);
	logic busy;
	logic [5:0] left;
	// One done or fail pulse per started extent, after a short or long spin
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			left <= 6'h00;
			med_done <= 1'b0;
			med_fail <= 1'b0;
		end else begin
			med_done <= 1'b0;
			med_fail <= 1'b0;
			if (med_start) begin
				busy <= 1'b1;
				left <= slow ? 6'h28 : 6'h04;
			end else if (busy && left == 6'h00) begin
				busy <= 1'b0;
				med_fail <= fail_all;
				med_done <= !fail_all;
			end else if (busy) begin
				left <= left - 6'h01;
			end
		end
	end
	// Spare area answers each reassignment request once
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reassign_ok <= 1'b0;
			reassign_fail <= 1'b0;
		end else begin
			reassign_ok <= reassign_req && spare_ok;
			reassign_fail <= reassign_req && !spare_ok;
		end
	end
endmodule

// ==== dv/disk_write_cache_control_bench.sv ====
// Self-checking bench of the disk write cache controller
`timescale 1ns/100ps
`include "wcache_map.svh"
module disk_write_cache_control_bench;
	logic sys_clk, rst, cmd_valid, host_xfer_done, hard_reset_req;
	logic soft_reset_req, slow, fail_all, spare_ok, cmd_ready, xfer_go;
	logic cmd_pass, irq_done, irq_abort, stat_ok, stat_err, cache_en;
	logic hard_go, soft_go, med_start, med_seek, med_done, med_fail;
	logic reassign_req, reassign_ok, reassign_fail, pending;
	logic [7:0] cmd_opcode, cmd_feature, cmd_count, med_count;
	logic [27:0] cmd_lba, med_lba;
	int fail_count, checks, n_start, n_abort;
	wire [7:0] ev = {irq_done, irq_abort, xfer_go, cmd_pass, soft_go, hard_go,
		med_start, reassign_req};
	localparam int DONE = 7, ABORT = 6, XGO = 5, PASS = 4, START = 1, REQ = 0;
	localparam logic [7:0] OPS [3] = '{`OP_WRITE_SECTORS, `OP_WRITE_MULTIPLE,
		`OP_WRITE_DMA};

	disk_write_cache_control #(.RETRIES(2)) uut (.*);
	wcache_medium_model partner (.*);

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Pulse counters for medium starts and abnormal ends
	always @(posedge sys_clk) begin
		if (med_start === 1'b1) n_start++;
		if (irq_abort === 1'b1) n_abort++;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_ev(input int idx, input int lim, output int n);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (ev[idx] !== 1'b1 && n < lim);
		chk(ev[idx], 1'b1);
	endtask
	task automatic send(input logic [7:0] op, input logic [7:0] feat,
		input logic [27:0] lba, input logic [7:0] cnt);
		logic r;
		int n;
		n = 0;
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_opcode <= op;
		cmd_feature <= feat;
		cmd_lba <= lba;
		cmd_count <= cnt;
		do begin
			@(negedge sys_clk);
			r = cmd_ready;
			@(posedge sys_clk);
			n++;
		end while (r !== 1'b1 && n < 500);
		cmd_valid <= 1'b0;
		chk(r, 1'b1);
	endtask
	task automatic wr(input logic [7:0] op, input logic [27:0] lba,
		input logic [7:0] cnt);
		int n;
		send(op, 8'h00, lba, cnt);
		wait_ev(XGO, 2, n);
		@(posedge sys_clk);
		host_xfer_done <= 1'b1;
		@(posedge sys_clk);
		host_xfer_done <= 1'b0;
	endtask
	task automatic drain;
		int n;
		n = 0;
		while (pending !== 1'b0 && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		chk(pending, 1'b0);
	endtask
	task automatic feat(input logic [7:0] f);
		int n;
		send(`OP_SET_FEATURES, f, 28'h0, 8'h00);
		wait_ev(DONE, 300, n);
	endtask
	task automatic err(input logic good);
		int n, s;
		fail_all <= 1'b1;
		spare_ok <= good;
		s = n_start;
		wr(`OP_WRITE_SECTORS, 28'h500, 8'h01);
		wait_ev(DONE, 3, n);
		wait_ev(REQ, 300, n);
		chk(n_start - s, 3);
		fail_all <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_basic;
		int n;
		chk(cache_en, 1'b1);
		for (int i = 0; i < 3; i++) begin
			wr(OPS[i], 28'(i * 16), 8'h04);
			wait_ev(DONE, 3, n);
			chk(stat_ok, 1'b1);
			chk(pending, 1'b1);
			drain();
		end
		send(8'h20, 8'h00, 28'h0, 8'h01);
		wait_ev(PASS, 2, n);
		send(`OP_SET_FEATURES, 8'h03, 28'h0, 8'h00);
		wait_ev(PASS, 2, n);
		chk(cache_en, 1'b1);
	endtask
	task automatic t_seq;
		wr(`OP_WRITE_DMA, 28'h100, 8'h04);
		wr(`OP_WRITE_DMA, 28'h104, 8'h04);
		drain();
		chk(med_lba, 28'h104);
		chk(med_count, 8'h04);
		chk(med_seek, 1'b0);
		wr(`OP_WRITE_DMA, 28'h200, 8'h04);
		wr(`OP_WRITE_SECTORS, 28'h300, 8'h02);
		drain();
		chk(med_lba, 28'h300);
		chk(med_seek, 1'b1);
		wr(`OP_WRITE_SECTORS, 28'h302, 8'h02);
		drain();
		chk(med_seek, 1'b1);
	endtask
	task automatic t_defer;
		int n;
		wr(`OP_WRITE_DMA, 28'h400, 8'h04);
		feat(`FEAT_WC_DISABLE);
		chk(pending, 1'b0);
		chk(cache_en, 1'b0);
		// With caching off a write completes only once it is on the medium
		wr(`OP_WRITE_DMA, 28'h408, 8'h04);
		wait_ev(DONE, 300, n);
		chk(n > 20, 1'b1);
		chk(pending, 1'b0);
		feat(`FEAT_WC_ENABLE);
		chk(cache_en, 1'b1);
		for (int i = 0; i < 2; i++) begin
			wr(`OP_WRITE_DMA, 28'h410, 8'h04);
			@(posedge sys_clk);
			soft_reset_req <= (i == 0);
			hard_reset_req <= (i == 1);
			@(posedge sys_clk);
			soft_reset_req <= 1'b0;
			hard_reset_req <= 1'b0;
			wait_ev(3 - i, 300, n);
			chk(n > 20, 1'b1);
			chk(pending, 1'b0);
		end
	endtask
	task automatic t_err;
		int n, s, a;
		slow <= 1'b0;
		err(1'b0);
		chk(cache_en, 1'b0);
		send(8'h20, 8'h00, 28'h0, 8'h01);
		wait_ev(ABORT, 3, n);
		chk(stat_err, 1'b1);
		// Caching is turned back on only after the error has been seen
		feat(`FEAT_WC_ENABLE);
		err(1'b0);
		s = n_start;
		wr(`OP_WRITE_SECTORS, 28'h600, 8'h02);
		wait_ev(ABORT, 300, n);
		chk(n_start - s, 1);
		chk(med_lba, 28'h600);
		feat(`FEAT_WC_ENABLE);
		err(1'b1);
		a = n_abort;
		send(8'h20, 8'h00, 28'h0, 8'h01);
		wait_ev(PASS, 3, n);
		chk(n_abort - a, 0);
		chk(cache_en, 1'b1);
	endtask

	task automatic results;
		$display("Checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{rst, cmd_valid, host_xfer_done, hard_reset_req} = 4'hf;
		{soft_reset_req, fail_all, spare_ok} = 3'h0;
		{cmd_valid, host_xfer_done, hard_reset_req} = 3'h0;
		slow = 1'b1;
		cmd_opcode = 8'h00;
		cmd_feature = 8'h00;
		cmd_count = 8'h00;
		cmd_lba = 28'h0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_basic();
		t_seq();
		t_defer();
		t_err();
		results();
	end
	// Watchdog cuts a hang short
	initial begin
		repeat (60000) @(posedge sys_clk);
		fail_count++;
		$display("ERROR %0t: timeout", $time);
		results();
	end
endmodule
